// File: logic/t8w_timer.sv
// Eight-bit timer with compare output unit, AHB-Lite registers and pin override
`timescale 1ns/10ps
`include "t8w_map.svh"

module t8w_timer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic comp_pin_in,
	output logic comp_pin_out,
	output logic comp_pin_oe
);
	import t8w_pkg::*;

	// Bus side state
	t8w_bus_st_t bus_q;
	t8w_bus_st_t bus_d;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_word;

	// Timer state
	t8w_ctrl_t ctrl_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] ocr_q;
	logic [7:0] ocr_d;
	logic [7:0] ocr_buf_q;
	logic ovf_q;
	logic cmp_q;
	logic oc_q;
	logic oc_d;
	logic blk_q;
	logic port_q;
	logic dir_q;
	logic pin_out_q;
	logic pin_s1_q;
	logic pin_s2_q;

	// Decoded events
	wire tick;
	wire addr_take;
	wire wr_phase;
	wire wr_ctrl;
	wire wr_count;
	wire wr_compare;
	wire wr_flags;
	wire wr_port;
	wire is_pwm;
	wire is_fast;
	wire is_clear;
	wire at_max;
	wire match;
	wire wrap;
	wire ovf_set;
	wire force_evt;
	wire t8w_wave_t new_wave;
	wire t8w_out_mode_t new_mode;

	t8w_prescaler u_pre (
		.hclk(hclk),
		.hresetn(hresetn),
		.clksel(ctrl_q.clksel),
		.tick(tick)
	);

	// Address phase is taken only when the bus is ready; whole words only, hsize is not checked
	assign addr_take = hsel && htrans[1] && hready;

	// Bus sequencer: writes finish with no wait, reads take one wait state to register data
	always_comb begin
		bus_d = BUS_IDLE;
		case (bus_q)
			BUS_READ: begin
				bus_d = BUS_READY;
			end
			default: begin
				if (addr_take) begin
					bus_d = hwrite ? BUS_WRITE : BUS_READ;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_q <= BUS_IDLE;
			addr_q <= `T8W_RST_BYTE;
		end else begin
			bus_q <= bus_d;
			if (addr_take) begin
				addr_q <= haddr[7:0];
			end
		end
	end

	assign hreadyout = (bus_q != BUS_READ);
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// Write strobes in the data phase
	assign wr_phase = (bus_q == BUS_WRITE);
	assign wr_ctrl = wr_phase && (addr_q == `T8W_OFF_CTRL);
	assign wr_count = wr_phase && (addr_q == `T8W_OFF_COUNT);
	assign wr_compare = wr_phase && (addr_q == `T8W_OFF_COMPARE);
	assign wr_flags = wr_phase && (addr_q == `T8W_OFF_FLAGS);
	assign wr_port = wr_phase && (addr_q == `T8W_OFF_PORT);

	// Read mux; unmapped offsets read zero, the force strobe always reads zero
	always_comb begin
		rd_word = `T8W_RST_WORD;
		if (addr_q == `T8W_OFF_CTRL) begin
			rd_word[`T8W_CTRL_WAVE] = ctrl_q.wave;
			rd_word[`T8W_CTRL_MODE] = ctrl_q.out_mode;
			rd_word[`T8W_CTRL_CSEL] = ctrl_q.clksel;
		end else if (addr_q == `T8W_OFF_COUNT) begin
			rd_word[7:0] = cnt_q;
		end else if (addr_q == `T8W_OFF_COMPARE) begin
			rd_word[7:0] = ocr_buf_q;
		end else if (addr_q == `T8W_OFF_FLAGS) begin
			rd_word[`T8W_FLAG_OVF] = ovf_q;
			rd_word[`T8W_FLAG_CMP] = cmp_q;
		end else if (addr_q == `T8W_OFF_PORT) begin
			rd_word[`T8W_PORT_DATA] = port_q;
			rd_word[`T8W_PORT_DIR] = dir_q;
		end else if (addr_q == `T8W_OFF_STATUS) begin
			rd_word[`T8W_STAT_OC] = oc_q;
			rd_word[`T8W_STAT_PIN] = pin_s2_q;
			rd_word[`T8W_STAT_ACTIVE] = ocr_q;
		end
	end

	// Read data is captured during the wait state so it sees any write just before it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= `T8W_RST_WORD;
		end else if (bus_q == BUS_READ) begin
			hrdata_q <= rd_word;
		end
	end

	// Mode decode; counting depends on the waveform mode alone
	assign is_fast = (ctrl_q.wave == WAVE_FAST);
	assign is_clear = (ctrl_q.wave == WAVE_CLEAR);
	assign is_pwm = is_fast || (ctrl_q.wave == WAVE_PHASE);
	assign at_max = (cnt_q == `T8W_MAX);

	// Match seen at a tick is flagged at that tick, one timer clock after the equal count
	assign match = tick && !blk_q && (cnt_q == ocr_q);
	// Wrap from the top to zero; in clear-on-match mode a match clear takes its place
	assign wrap = tick && at_max && !(is_clear && match);
	assign ovf_set = tick && at_max;

	// Force strobe acts with the values written in the same access
	assign new_wave = t8w_wave_t'(hwdata[`T8W_CTRL_WAVE]);
	assign new_mode = t8w_out_mode_t'(hwdata[`T8W_CTRL_MODE]);
	assign force_evt = wr_ctrl && hwdata[`T8W_CTRL_FORCE] &&
		(new_wave != WAVE_FAST) && (new_wave != WAVE_PHASE);

	// Counter: a software write beats clear and count
	always_comb begin
		cnt_d = cnt_q;
		if (wr_count) begin
			cnt_d = hwdata[7:0];
		end else if (tick) begin
			if (is_clear && match) begin
				cnt_d = `T8W_BOTTOM;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	// Active compare value: direct in non-PWM modes, loaded from the buffer at wrap in PWM
	always_comb begin
		ocr_d = ocr_q;
		if (wr_compare && !is_pwm) begin
			ocr_d = hwdata[7:0];
		end else if (is_pwm && wrap) begin
			ocr_d = ocr_buf_q;
		end
	end

	// Compare output state; a mode change alone never touches it
	always_comb begin
		oc_d = oc_q;
		if (force_evt) begin
			case (new_mode)
				OUT_TOGGLE: oc_d = !oc_q;
				OUT_CLEAR: oc_d = 1'b0;
				OUT_SET: oc_d = 1'b1;
				default: oc_d = oc_q;
			endcase
		end else if (is_fast) begin
			// Wrap wins over a match at the top in output modes 2 and 3, so a compare of maximum holds a level there
			if (wrap && ctrl_q.out_mode == OUT_CLEAR) begin
				oc_d = 1'b1;
			end else if (wrap && ctrl_q.out_mode == OUT_SET) begin
				oc_d = 1'b0;
			end else if (match) begin
				case (ctrl_q.out_mode)
					OUT_TOGGLE: oc_d = !oc_q;
					OUT_CLEAR: oc_d = 1'b0;
					OUT_SET: oc_d = 1'b1;
					default: oc_d = oc_q;
				endcase
			end
		end else if (!is_pwm && match) begin
			// Output mode is read live, so a new setting governs the next match
			case (ctrl_q.out_mode)
				OUT_TOGGLE: oc_d = !oc_q;
				OUT_CLEAR: oc_d = 1'b0;
				OUT_SET: oc_d = 1'b1;
				default: oc_d = oc_q;
			endcase
		end
	end

	// Control, counter, compare and output state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= '0;
			cnt_q <= `T8W_RST_BYTE;
			ocr_q <= `T8W_RST_BYTE;
			ocr_buf_q <= `T8W_RST_BYTE;
			oc_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q.wave <= new_wave;
				ctrl_q.out_mode <= new_mode;
				ctrl_q.clksel <= t8w_clksel_t'(hwdata[`T8W_CTRL_CSEL]);
			end
			if (wr_compare) begin
				ocr_buf_q <= hwdata[7:0];
			end
			cnt_q <= cnt_d;
			ocr_q <= ocr_d;
			oc_q <= oc_d;
		end
	end

	// Match blocker: set by any counter write, even when stopped, and held until the next tick consumes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			blk_q <= 1'b0;
		end else if (wr_count) begin
			blk_q <= 1'b1;
		end else if (tick) begin
			blk_q <= 1'b0;
		end
	end

	// Sticky flags, cleared by writing one; a set in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_q <= 1'b0;
			cmp_q <= 1'b0;
		end else begin
			ovf_q <= ovf_set || (ovf_q && !(wr_flags && hwdata[`T8W_FLAG_OVF]));
			// A forced compare never reaches this flag
			cmp_q <= match || (cmp_q && !(wr_flags && hwdata[`T8W_FLAG_CMP]));
		end
	end

	// Port data and direction, plus the synchronised pin level for readback
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_q <= 1'b0;
			dir_q <= 1'b0;
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			if (wr_port) begin
				port_q <= hwdata[`T8W_PORT_DATA];
				dir_q <= hwdata[`T8W_PORT_DIR];
			end
			pin_s1_q <= comp_pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Pin source: compare state whenever output mode is nonzero, in every waveform mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out_q <= 1'b0;
		end else begin
			pin_out_q <= (ctrl_q.out_mode != OUT_OFF) ? oc_q : port_q;
		end
	end

	assign comp_pin_out = pin_out_q;
	// Direction stays with software; it should prime the state before enabling the pin
	assign comp_pin_oe = dir_q;

endmodule

// File: common/t8w_map.svh
// Register offsets, field positions, reset values and counts of the timer waveform unit
// How it works
// - Changing the waveform mode never alters the compare output state bit.
// - Output mode changes act at the first compare match after the write.
// - A nonzero output mode puts the compare output state on the pin.
// - The pin override is the same in every waveform mode.
// - Output mode zero leaves the compare output state alone on matches.
// - Force strobe applies the configured action at once in non-PWM modes.
// - Only the waveform mode shapes counting; output mode selects pin action.
// - Mode 0 counts up only and wraps from 0xFF to 0x00.
// - Normal mode sets the overflow flag as the counter becomes zero.
// - Normal mode accepts a counter write at any time.
// - Mode 2 clears the counter when it matches the compare value.
// - A compare value below the count is reached only after wrapping.
// - Clear-on-match mode raises the compare flag every period.
// - Clear-on-match mode with output mode 1 toggles on each match.
// - Toggle period is two times prescale times one plus compare value.
// - Clear-on-match mode sets overflow as the count passes 0xFF to 0x00.
// - Mode 3 counts from zero to 0xFF, then clears: 256 timer clocks.
// - Fast PWM mode 2 clears on match, sets at wrap; mode 3 inverts.
// - Fast PWM sets the overflow flag each time the counter passes from maximum to zero.
// - Fast PWM output modes 2 and 3: compare zero gives a one-clock spike; maximum gives constant level.
// - Fast PWM output mode 1 toggles on match, compare stays double buffered.
// - PWM modes load the compare value from a buffer at wrap; others directly.
// - A count equal to the compare value sets the flag next timer clock.
// - A forced compare sets no flag and leaves the counter alone.
// - A counter write blocks the compare match of the next timer clock.
`ifndef T8W_MAP_SVH
`define T8W_MAP_SVH

// Byte offsets on the register bus
`define T8W_OFF_CTRL 8'h00
`define T8W_OFF_COUNT 8'h04
`define T8W_OFF_COMPARE 8'h08
`define T8W_OFF_FLAGS 8'h0C
`define T8W_OFF_PORT 8'h10
`define T8W_OFF_STATUS 8'h14

// Control register fields
`define T8W_CTRL_WAVE 1:0
`define T8W_CTRL_MODE 3:2
`define T8W_CTRL_CSEL 6:4
`define T8W_CTRL_FORCE 7

// Flag register, port register and status register fields
`define T8W_FLAG_OVF 0
`define T8W_FLAG_CMP 1
`define T8W_PORT_DATA 0
`define T8W_PORT_DIR 1
`define T8W_STAT_OC 0
`define T8W_STAT_PIN 1
`define T8W_STAT_ACTIVE 15:8

// Counter extremes and reset values
`define T8W_MAX 8'hFF
`define T8W_BOTTOM 8'h00
`define T8W_RST_BYTE 8'h00
`define T8W_RST_WORD 32'h0000_0000

// Prescaler masks: a tick when the free count has all masked bits set
`define T8W_PRE_W 10
`define T8W_MASK_1 10'h000
`define T8W_MASK_8 10'h007
`define T8W_MASK_32 10'h01F
`define T8W_MASK_64 10'h03F
`define T8W_MASK_128 10'h07F
`define T8W_MASK_256 10'h0FF
`define T8W_MASK_1024 10'h3FF

`endif

// File: common/t8w_pkg.sv
// Types shared by the timer waveform unit and its prescaler
package t8w_pkg;

	typedef enum logic [1:0] {
		WAVE_NORMAL = 2'b00,
		WAVE_PHASE = 2'b01,
		WAVE_CLEAR = 2'b10,
		WAVE_FAST = 2'b11
	} t8w_wave_t;

	typedef enum logic [1:0] {
		OUT_OFF = 2'b00,
		OUT_TOGGLE = 2'b01,
		OUT_CLEAR = 2'b10,
		OUT_SET = 2'b11
	} t8w_out_mode_t;

	typedef enum logic [2:0] {
		CSEL_STOP = 3'b000,
		CSEL_DIV1 = 3'b001,
		CSEL_DIV8 = 3'b010,
		CSEL_DIV32 = 3'b011,
		CSEL_DIV64 = 3'b100,
		CSEL_DIV128 = 3'b101,
		CSEL_DIV256 = 3'b110,
		CSEL_DIV1024 = 3'b111
	} t8w_clksel_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10,
		BUS_READY = 2'b11
	} t8w_bus_st_t;

	typedef struct packed {
		t8w_clksel_t clksel;
		t8w_out_mode_t out_mode;
		t8w_wave_t wave;
	} t8w_ctrl_t;

endpackage

// File: logic/t8w_prescaler.sv
// Prescaler that turns the bus clock into the one-cycle timer tick
`timescale 1ns/10ps
`include "t8w_map.svh"

module t8w_prescaler (
	input wire logic hclk,
	input wire logic hresetn,
	input wire t8w_pkg::t8w_clksel_t clksel,
	output logic tick
);
	import t8w_pkg::*;

	logic [`T8W_PRE_W-1:0] pre_q;
	logic [`T8W_PRE_W-1:0] mask;

	// Free running count; it is never restarted, so a new division starts mid-phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_q + 1'b1;
		end
	end

	// Mask per division ratio
	always_comb begin
		case (clksel)
			CSEL_DIV1: mask = `T8W_MASK_1;
			CSEL_DIV8: mask = `T8W_MASK_8;
			CSEL_DIV32: mask = `T8W_MASK_32;
			CSEL_DIV64: mask = `T8W_MASK_64;
			CSEL_DIV128: mask = `T8W_MASK_128;
			CSEL_DIV256: mask = `T8W_MASK_256;
			CSEL_DIV1024: mask = `T8W_MASK_1024;
			default: mask = `T8W_MASK_1;
		endcase
	end

	// Stopped selection gives no tick at all
	assign tick = (clksel != CSEL_STOP) && ((pre_q & mask) == mask);

endmodule

// File: bench/t8w_props.sv
// Checker of the timer's bus handshake and compare pin override
`timescale 1ns/10ps
module t8w_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic comp_pin_out,
	input wire logic comp_pin_oe
);
	logic wr_q;
	logic rd_q;
	logic [7:0] adr_q;
	logic [1:0] mode_q;
	wire take = hsel && htrans[1] && hready;
	wire wr_end = wr_q && hready;
	wire rd_end = rd_q && hready;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Data phase tracking; read waits hold it, so the address stays with its data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			adr_q <= 8'h00;
			mode_q <= 2'h0;
		end else if (hready) begin
			wr_q <= take && hwrite;
			rd_q <= take && !hwrite;
			adr_q <= haddr[7:0];
			if (wr_end && adr_q == 8'h00) mode_q <= hwdata[3:2];
		end
	end
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	a_wait_cause: assert property (!hreadyout |-> $past(take && !hwrite)) else $error("stray wait");
	a_force_zero: assert property (rd_end && adr_q == 8'h00 |-> !hrdata[7]) else $error("force read 1");
	a_dir_bit: assert property (wr_end && adr_q == 8'h10 |=> comp_pin_oe == $past(hwdata[1]))
		else $error("pin enable wrong");
	a_pin_port: assert property (wr_end && adr_q == 8'h10 && mode_q == 2'h0 |=> ##1
		comp_pin_out == $past(hwdata[0], 2)) else $error("port data not on pin");
	a_pin_state: assert property (rd_end && adr_q == 8'h14 && mode_q != 2'h0 |->
		comp_pin_out == hrdata[0]) else $error("state not on pin");
	c_status: cover property (rd_end && adr_q == 8'h14);
	c_port: cover property (wr_end && adr_q == 8'h10);
	c_rise: cover property ($rose(comp_pin_out));
endmodule

bind t8w_timer t8w_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.comp_pin_out(comp_pin_out), .comp_pin_oe(comp_pin_oe));

// File: bench/test_timer8_compare_waveform_unit.sv
// Self-checking bench for the timer waveform unit
`timescale 1ns/10ps
module test_timer8_compare_waveform_unit;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout;
	logic [31:0] hrdata;
	logic comp_pin_out;
	logic comp_pin_oe;
	wire comp_pin_in = comp_pin_oe ? comp_pin_out : 1'b1; // Pull-up when released
	int n_mismatch;
	int checks;
	int cyc;
	int w;
	logic [31:0] rd;
	logic [7:0] cv;
	logic [7:0] ctl [10] = '{8'h8C, 8'h8A, 8'h86, 8'h84, 8'h80, 8'h8F, 8'h8C, 8'h03, 8'h02, 8'h00};
	logic st [10] = '{1, 0, 1, 0, 0, 0, 1, 1, 1, 1};
	logic [7:0] wv [4] = '{8'h00, 8'h0C, 8'h03, 8'h0F};

	t8w_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
		.comp_pin_in(comp_pin_in), .comp_pin_out(comp_pin_out), .comp_pin_oe(comp_pin_oe));

	// Comparison, counter lap tolerance and bus helpers
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic near(logic [7:0] v, logic [7:0] e);
		logic [7:0] d;
		d = v - e;
		return d <= 8'h02 || d >= 8'hFE;
	endfunction
	// Ready and read data are taken at the rising edge, before the design's own updates land
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task automatic setup(logic [7:0] c, logic [7:0] n, logic [7:0] m);
		bus(1'b1, 8'h00, {24'h0, c});
		bus(1'b1, 8'h08, {24'h0, m});
		bus(1'b1, 8'h04, {24'h0, n});
		bus(1'b1, 8'h0C, 32'h3);
	endtask
	task automatic run(logic [7:0] c, int k);
		bus(1'b1, 8'h00, {24'h0, c | 8'h10});
		repeat (k) @(posedge hclk);
		bus(1'b1, 8'h00, {24'h0, c});
	endtask
	// Length of the next pulse at level lv, capped so a stuck pin ends
	task automatic width(logic lv, output int n);
		n = 0;
		repeat (600) begin
			@(negedge hclk);
			if (comp_pin_out !== lv) break;
		end
		repeat (600) begin
			@(negedge hclk);
			if (comp_pin_out === lv) break;
		end
		while (n < 600 && comp_pin_out === lv) begin
			n++;
			@(negedge hclk);
		end
		@(posedge hclk);
	endtask
	task automatic give_verdict();
		$display("Mismatches %0d of %0d checks", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// Hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		void'($urandom(32'h116F));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int a = 0; a < 7; a++) begin
			bus(1'b0, 8'(a * 4), 32'h0);
			chk("reset word", (a == 5) ? 32'h2 : 32'h0, rd);
		end
		// Forced actions with the clock stopped, then mode changes
		cv = 8'($urandom);
		bus(1'b1, 8'h04, {24'h0, cv});
		bus(1'b1, 8'h10, 32'h1);
		repeat (2) @(negedge hclk);
		chk("pin port", 1, comp_pin_out);
		@(posedge hclk);
		foreach (ctl[i]) begin
			bus(1'b1, 8'h00, {24'h0, ctl[i]});
			bus(1'b0, 8'h14, 32'h0);
			chk("state", st[i], rd[0]);
		end
		bus(1'b0, 8'h04, 32'h0);
		chk("count kept", cv, rd);
		bus(1'b0, 8'h0C, 32'h0);
		chk("force flags", 0, rd);
		// Wrap past the maximum; output mode must not alter counting
		foreach (wv[i]) begin
			setup(wv[i], 8'hF8, 8'h80);
			run(wv[i], 14);
			bus(1'b0, 8'h04, 32'h0);
			chk("wrap count", 1, near(rd[7:0], 8'h08));
			bus(1'b0, 8'h0C, 32'h0);
			chk("wrap flags", 1, rd);
		end
		cv = 8'(3 + $urandom_range(6, 0));
		setup(8'h02, 8'h00, cv);
		run(8'h02, 40);
		bus(1'b0, 8'h04, 32'h0);
		chk("top bound", 1, rd[7:0] <= cv);
		bus(1'b0, 8'h0C, 32'h0);
		chk("top flags", 2, rd);
		// Compare below the count, then a count write equal to compare
		for (int i = 0; i < 2; i++) begin
			cv = i ? 8'h05 : 8'h20;
			setup(8'h02, cv, 8'h05);
			run(8'h02, 10);
			bus(1'b0, 8'h04, 32'h0);
			chk("missed match", 1, near(rd[7:0], cv + 8'h0C));
			bus(1'b0, 8'h0C, 32'h0);
			chk("no match flag", 0, rd);
		end
		bus(1'b1, 8'h10, 32'h2);
		for (int i = 0; i < 2; i++) begin
			cv = i ? 8'($urandom_range(20, 1)) : 8'h00;
			setup(8'h06, 8'h00, cv);
			bus(1'b1, 8'h00, 32'h16);
			width(1'b1, w);
			chk("toggle half", cv + 1, w);
		end
		// Fast PWM pulses of both polarities, zero compare included
		for (int i = 0; i < 4; i++) begin
			cv = i[0] ? 8'($urandom_range(254, 1)) : 8'h00;
			setup(i[1] ? 8'h0F : 8'h0B, 8'h00, cv);
			bus(1'b1, 8'h00, i[1] ? 32'h1F : 32'h1B);
			width(!i[1], w);
			chk("pwm pulse", cv + 1, w);
		end
		setup(8'h0B, 8'h00, 8'hFF);
		bus(1'b1, 8'h00, 32'h1B);
		repeat (520) @(negedge hclk);
		w = 0;
		repeat (300) begin
			@(negedge hclk);
			w += (comp_pin_out === 1'b1);
		end
		chk("max level", 300, w);
		give_verdict();
	end
endmodule
